/* File: src/dds_cfg.svh */
`ifndef DDS_CFG_SVH
`define DDS_CFG_SVH

// datapath widths
`define ACC_W          24
`define FREQ_W         22
`define DEV_W          8
`define DEV_LSB        2
`define DAC_W          11
`define LUT_ADDR_W     6
`define QTR_ADDR_W     4

// serial control word layout
`define WORD_W         24
`define ADDR_HI        23
`define ADDR_LO        22
`define MM_BIT         16
`define DEV_HI         7
`define DEV_LO         0

// latch address codes in the top two word bits
`define ADDR_FREQ0     2'h0
`define ADDR_FREQ1     2'h1
`define ADDR_CTRL      2'h2
`define ADDR_OTHER     2'h3

// reset values
`define FREQ_RST       22'h000000
`define DEV_RST        8'h00
`define MM_RST         1'h1
`define ACC_RST        24'h000000
`define WORD_RST       24'h000000
`define DAC_MID        11'h400

`endif

/* File: src/dds_pkg.sv */
package dds_pkg;

    typedef logic [23:0] word_type;
    typedef logic [21:0] freq_type;
    typedef logic [7:0]  dev_type;
    typedef logic [10:0] sample_type;

    typedef enum logic [1:0] {
        LATCH_FREQ0 = 2'b00,
        LATCH_FREQ1 = 2'b01,
        LATCH_CTRL  = 2'b10,
        LATCH_OTHER = 2'b11
    } latch_sel_type;

endpackage : dds_pkg

/* File: src/serial_word_loader.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dds_cfg.svh"

module serial_word_loader (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              ce,
    input  wire logic              ser_clock,
    input  wire logic              ser_data,
    input  wire logic              ser_strobe,
    output var  dds_pkg::word_type word,
    output var  logic              load
);

    logic              clk_s1_r;
    logic              clk_s2_r;
    logic              clk_s3_r;
    logic              dat_s1_r;
    logic              dat_s2_r;
    logic              stb_s1_r;
    logic              stb_s2_r;
    logic              stb_s3_r;
    dds_pkg::word_type shift_r;
    dds_pkg::word_type word_r;
    logic              load_r;
    wire logic         clk_rise;
    wire logic         stb_rise;

    ////////////////////////////////////////////////////////////////////////
    // edges seen only behind the second synchroniser stage
    assign clk_rise = clk_s2_r & ~clk_s3_r;
    assign stb_rise = stb_s2_r & ~stb_s3_r;
    assign word     = word_r;
    assign load     = load_r;

    // two-flop synchronisers for the asynchronous serial pins
    always_ff @(posedge clk) begin
        if (srst) begin
            {clk_s1_r, clk_s2_r, clk_s3_r} <= 3'h0;
            {dat_s1_r, dat_s2_r}           <= 2'h0;
            {stb_s1_r, stb_s2_r, stb_s3_r} <= 3'h0;
        end else if (ce) begin
            {clk_s1_r, clk_s2_r, clk_s3_r} <= {ser_clock, clk_s1_r, clk_s2_r};
            {dat_s1_r, dat_s2_r}           <= {ser_data, dat_s1_r};
            {stb_s1_r, stb_s2_r, stb_s3_r} <= {ser_strobe, stb_s1_r, stb_s2_r};
        end
    end

    // msb first; older leading bits fall off the top
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_r <= `WORD_RST;
        end else if (ce && clk_rise) begin
            shift_r <= {shift_r[`WORD_W-2:0], dat_s2_r};
        end
    end

    // strobe rise hands the last 24 bits over as a one-cycle load
    always_ff @(posedge clk) begin
        if (srst) begin
            word_r <= `WORD_RST;
            load_r <= 1'b0;
        end else if (ce) begin
            load_r <= stb_rise;
            if (stb_rise) begin
                word_r <= shift_r;
            end
        end
    end

    property p_strobe_load;
        @(posedge clk) disable iff (srst)
        (ce && stb_rise) |=> (load_r && word_r == $past(shift_r));
    endproperty
    a_strobe_load: assert property (p_strobe_load)
        else $error("strobe edge did not load the shifted word");

    property p_shift_keep;
        @(posedge clk) disable iff (srst)
        (ce && clk_rise) |=>
            (shift_r[`WORD_W-1:1] == $past(shift_r[`WORD_W-2:0]));
    endproperty
    a_shift_keep: assert property (p_shift_keep)
        else $error("shift register did not keep the low bits");

endmodule : serial_word_loader
`default_nettype wire

/* File: src/sine_lut.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dds_cfg.svh"

module sine_lut (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    ce,
    input  wire logic [`LUT_ADDR_W-1:0]  addr,
    output var  dds_pkg::sample_type     rd_data
);

    dds_pkg::sample_type rd_data_r;

    ////////////////////////////////////////////////////////////////////////
    // quarter-wave table folded by the two top phase bits
    function automatic dds_pkg::sample_type sine_of(
        input logic [`LUT_ADDR_W-1:0] a
    );
        logic [`QTR_ADDR_W-1:0] idx;
        logic [9:0]             mag;
        idx = a[4] ? ~a[3:0] : a[3:0];
        unique case (idx)
            4'h0: mag = 10'h032;
            4'h1: mag = 10'h096;
            4'h2: mag = 10'h0F9;
            4'h3: mag = 10'h159;
            4'h4: mag = 10'h1B5;
            4'h5: mag = 10'h20E;
            4'h6: mag = 10'h261;
            4'h7: mag = 10'h2AF;
            4'h8: mag = 10'h2F6;
            4'h9: mag = 10'h336;
            4'hA: mag = 10'h36D;
            4'hB: mag = 10'h39D;
            4'hC: mag = 10'h3C3;
            4'hD: mag = 10'h3E0;
            4'hE: mag = 10'h3F4;
            4'hF: mag = 10'h3FE;
        endcase
        sine_of = a[5] ? (`DAC_MID - {1'b0, mag}) : (`DAC_MID + {1'b0, mag});
    endfunction : sine_of

    assign rd_data = rd_data_r;

    // registered read of the sample for this phase
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_r <= `DAC_MID;
        end else if (ce) begin
            rd_data_r <= sine_of(addr);
        end
    end

    property p_lut_read;
        @(posedge clk) disable iff (srst)
        (ce && !srst) |=> (rd_data_r == sine_of($past(addr)));
    endproperty
    a_lut_read: assert property (p_lut_read)
        else $error("sine sample does not match the addressed phase");

endmodule : sine_lut
`default_nettype wire

/* File: src/dds_frequency_synth_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dds_cfg.svh"

module dds_frequency_synth_core (
    input  wire logic                MCLK,
    input  wire logic                SRST,
    input  wire logic                CE,
    input  wire logic                SER_CLOCK,
    input  wire logic                SER_DATA,
    input  wire logic                SER_STROBE,
    input  wire logic                MODE,
    input  wire logic                TX_DATA,
    input  wire logic                STDBY,
    output var  dds_pkg::sample_type DAC_SAMPLE,
    output var  logic [`ACC_W-1:0]   PHASE
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    // pin synchronisers
    logic [2:0]              pin_s1_r;
    logic [2:0]              pin_s2_r;
    wire logic               mode_s;
    wire logic               txd_s;
    wire logic               stdby_s;

    // serial word hand-over
    dds_pkg::word_type       word;
    logic                    load;
    dds_pkg::latch_sel_type  latch_sel;
    wire logic               load_freq0;
    wire logic               load_freq1;
    wire logic               load_ctrl;

    // stored settings
    dds_pkg::freq_type       freq_zero_r;
    dds_pkg::freq_type       freq_one_r;
    dds_pkg::dev_type        shift_step_r;
    logic                    mod_sel_r;

    // step and phase
    dds_pkg::freq_type       freq_sel;
    logic [`ACC_W-1:0]       base_step;
    logic [`ACC_W-1:0]       dev_step;
    wire logic               fsk_on;
    logic [`ACC_W-1:0]       step;
    logic [`ACC_W-1:0]       acc_r;
    logic [`ACC_W-1:0]       acc_nxt;
    wire logic               run;

    // sample path
    dds_pkg::sample_type     lut_data;
    dds_pkg::sample_type     dac_r;

    ////////////////////////////////////////////////////////////////////////
    // functions

    // frequency setting placed in the step word, top two bits zero
    function automatic logic [`ACC_W-1:0] place_freq(
        input dds_pkg::freq_type f
    );
        place_freq = {2'h0, f};
    endfunction : place_freq

    // deviation placed with its two lowest positions at zero
    function automatic logic [`ACC_W-1:0] place_dev(
        input dds_pkg::dev_type d
    );
        place_dev = {14'h0000, d, 2'h0};
    endfunction : place_dev

    ////////////////////////////////////////////////////////////////////////
    // external pin synchronisers

    assign mode_s  = pin_s2_r[0];
    assign txd_s   = pin_s2_r[1];
    assign stdby_s = pin_s2_r[2];

    // mode, data and standby pass two flops before use
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
        end else if (CE) begin
            pin_s1_r <= {STDBY, TX_DATA, MODE};
            pin_s2_r <= pin_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial control port

    // 3-wire shift register and strobe load, active in standby too
    serial_word_loader u_loader (
        .clk        (MCLK),
        .srst       (SRST),
        .ce         (CE),
        .ser_clock  (SER_CLOCK),
        .ser_data   (SER_DATA),
        .ser_strobe (SER_STROBE),
        .word       (word),
        .load       (load)
    );

    // address decode of the received word
    assign latch_sel  = dds_pkg::latch_sel_type'(word[`ADDR_HI:`ADDR_LO]);
    assign load_freq0 = load && (latch_sel == dds_pkg::LATCH_FREQ0);
    assign load_freq1 = load && (latch_sel == dds_pkg::LATCH_FREQ1);
    assign load_ctrl  = load && (latch_sel == dds_pkg::LATCH_CTRL);

    ////////////////////////////////////////////////////////////////////////
    // setting latches

    // static latches; standby does not touch them
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            freq_zero_r <= `FREQ_RST;
            freq_one_r  <= `FREQ_RST;
        end else if (CE) begin
            if (load_freq0) begin
                freq_zero_r <= word[`FREQ_W-1:0];
            end
            if (load_freq1) begin
                freq_one_r <= word[`FREQ_W-1:0];
            end
        end
    end

    // control word carries modulation select and deviation
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            mod_sel_r    <= `MM_RST;
            shift_step_r <= `DEV_RST;
        end else if (CE && load_ctrl) begin
            mod_sel_r    <= word[`MM_BIT];
            shift_step_r <= word[`DEV_HI:`DEV_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // step selection

    // mode pin picks the active setting
    assign freq_sel  = mode_s ? freq_one_r : freq_zero_r;
    assign base_step = place_freq(freq_sel);

    // fsk only with select low and transmit data high
    assign fsk_on    = ~mod_sel_r & txd_s;
    assign dev_step  = fsk_on ? place_dev(shift_step_r) : `ACC_RST;
    assign step      = base_step + dev_step;

    ////////////////////////////////////////////////////////////////////////
    // phase accumulator

    // standby stops the ramp but keeps the phase
    assign run     = CE & ~stdby_s;
    assign acc_nxt = acc_r + step; // wraps at 2^24

    // reference-clock accumulator, never cleared by step changes
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            acc_r <= `ACC_RST;
        end else if (run) begin
            acc_r <= acc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sine lookup and DAC sample

    // top phase bits address the table
    sine_lut u_lut (
        .clk     (MCLK),
        .srst    (SRST),
        .ce      (CE),
        .addr    (acc_r[`ACC_W-1:`ACC_W-`LUT_ADDR_W]),
        .rd_data (lut_data)
    );

    // output registers
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            dac_r <= `DAC_MID;
        end else if (CE) begin
            dac_r <= lut_data;
        end
    end

    assign DAC_SAMPLE = dac_r;
    assign PHASE      = acc_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_acc_step;
        @(posedge MCLK) disable iff (SRST)
        run |=> (acc_r == $past(acc_r) + $past(step));
    endproperty
    a_acc_step: assert property (p_acc_step)
        else $error("accumulator did not advance by the step");

    property p_acc_hold;
        @(posedge MCLK) disable iff (SRST)
        (!CE || stdby_s) |=> $stable(acc_r);
    endproperty
    a_acc_hold: assert property (p_acc_hold)
        else $error("accumulator moved while frozen");

    property p_top_bits_zero;
        @(posedge MCLK) disable iff (SRST)
        !fsk_on |-> (step[`ACC_W-1:`ACC_W-2] == 2'h0);
    endproperty
    a_top_bits_zero: assert property (p_top_bits_zero)
        else $error("step top bits not zero");

    property p_mode_sel;
        @(posedge MCLK) disable iff (SRST)
        !fsk_on |-> (step == (mode_s ? {2'h0, freq_one_r}
                                     : {2'h0, freq_zero_r}));
    endproperty
    a_mode_sel: assert property (p_mode_sel)
        else $error("step not taken from the selected setting");

    property p_fsk_dev;
        @(posedge MCLK) disable iff (SRST)
        (!mod_sel_r && txd_s) |->
            (step == base_step + {14'h0000, shift_step_r, 2'h0});
    endproperty
    a_fsk_dev: assert property (p_fsk_dev)
        else $error("fsk step is not setting plus four times deviation");

    property p_fsk_gate;
        @(posedge MCLK) disable iff (SRST)
        mod_sel_r |-> (step == base_step);
    endproperty
    a_fsk_gate: assert property (p_fsk_gate)
        else $error("deviation applied with modulation select high");

    property p_keep_settings;
        @(posedge MCLK) disable iff (SRST)
        (stdby_s && !load) |=>
            ($stable(freq_zero_r) && $stable(freq_one_r)
             && $stable(shift_step_r));
    endproperty
    a_keep_settings: assert property (p_keep_settings)
        else $error("settings changed in standby without a load");

    property p_mode_change;
        @(posedge MCLK) disable iff (SRST)
        (run && $changed(mode_s)) |=>
            (acc_r == $past(acc_r) + $past(step));
    endproperty
    a_mode_change: assert property (p_mode_change)
        else $error("mode change disturbed the phase");

    property p_dac_follow;
        @(posedge MCLK) disable iff (SRST)
        CE |=> (dac_r == $past(lut_data));
    endproperty
    a_dac_follow: assert property (p_dac_follow)
        else $error("DAC sample does not follow the table");

    property p_freq0_load;
        @(posedge MCLK) disable iff (SRST)
        (CE && load_freq0) |=>
            (freq_zero_r == $past(word[`FREQ_W-1:0]));
    endproperty
    a_freq0_load: assert property (p_freq0_load)
        else $error("setting zero not taken from the loaded word");

    property p_freq1_load;
        @(posedge MCLK) disable iff (SRST)
        (CE && load_freq1) |=>
            (freq_one_r == $past(word[`FREQ_W-1:0]));
    endproperty
    a_freq1_load: assert property (p_freq1_load)
        else $error("setting one not taken from the loaded word");

    property p_ctrl_load;
        @(posedge MCLK) disable iff (SRST)
        (CE && load_ctrl) |=>
            (mod_sel_r == $past(word[`MM_BIT])
             && shift_step_r == $past(word[`DEV_HI:`DEV_LO]));
    endproperty
    a_ctrl_load: assert property (p_ctrl_load)
        else $error("control word not taken into select and deviation");

    // a word for the unused latch must leave every setting alone
    property p_other_refused;
        @(posedge MCLK) disable iff (SRST)
        (load && latch_sel == dds_pkg::LATCH_OTHER) |=>
            ($stable(freq_zero_r) && $stable(freq_one_r)
             && $stable(shift_step_r) && $stable(mod_sel_r));
    endproperty
    a_other_refused: assert property (p_other_refused)
        else $error("word for an unused latch changed a setting");

endmodule : dds_frequency_synth_core
`default_nettype wire

/* File: verification/serial_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// host programmer: shifts control words into the three-wire port
module serial_host_model (
    input  wire logic clk,
    output var  logic ser_clock,
    output var  logic ser_data,
    output var  logic ser_strobe
);

    // all lines idle low at start
    initial begin
        ser_clock  = 1'b0;
        ser_data   = 1'b0;
        ser_strobe = 1'b0;
    end

    // msb first, each level held well past the sync delay
    // four leading bits go first and must be dropped by the device
    task automatic send_word(input logic [27:0] bits);
        for (int i = 27; i >= 0; i--) begin
            @(posedge clk) ser_data <= bits[i];
            repeat (3) @(posedge clk);
            ser_clock <= 1'b1;
            repeat (4) @(posedge clk);
            ser_clock <= 1'b0;
            repeat (3) @(posedge clk);
            ser_data <= ~bits[i]; // hold over: show a changed level
        end
        // clock and data low before and while strobe is high
        @(posedge clk) ser_data <= 1'b0;
        repeat (3) @(posedge clk);
        ser_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        ser_strobe <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : send_word

endmodule : serial_host_model

`default_nettype wire

/* File: verification/test_dds_frequency_synth_core.sv */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module test_dds_frequency_synth_core;

    logic                mclk;
    logic                srst;
    logic                ce;
    logic                mode;
    logic                tx_data;
    logic                stdby;
    wire logic           ser_clock;
    wire logic           ser_data;
    wire logic           ser_strobe;
    dds_pkg::sample_type dac_sample;
    logic [23:0]         phase;
    int                  fails;
    int                  n_tests;
    dds_pkg::word_type   p_hold;

    ////////////////////////////////////////////////////////////////////////
    // design and host model
    dds_frequency_synth_core dut_u (
        .MCLK       (mclk),
        .SRST       (srst),
        .CE         (ce),
        .SER_CLOCK  (ser_clock),
        .SER_DATA   (ser_data),
        .SER_STROBE (ser_strobe),
        .MODE       (mode),
        .TX_DATA    (tx_data),
        .STDBY      (stdby),
        .DAC_SAMPLE (dac_sample),
        .PHASE      (phase)
    );

    serial_host_model host_u (
        .clk        (mclk),
        .ser_clock  (ser_clock),
        .ser_data   (ser_data),
        .ser_strobe (ser_strobe)
    );

    ////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // phase advance over one clock, modulo the accumulator width
    task automatic check_step(input string what,
                              input dds_pkg::word_type exp);
        dds_pkg::word_type p;
        @(posedge mclk) #1 p = phase;
        @(posedge mclk) #1 chk(what, exp, phase - p);
    endtask : check_step

    // every advance is old or new step (no phase reset), ends on new
    task automatic check_switch(input string what,
                                input dds_pkg::word_type old_s,
                                input dds_pkg::word_type new_s);
        dds_pkg::word_type p;
        dds_pkg::word_type d;
        @(posedge mclk) #1 p = phase;
        repeat (8) begin
            @(posedge mclk) #1 d = phase - p;
            p = phase;
            if (d !== old_s && d !== new_s) chk(what, new_s, d);
        end
        chk(what, new_s, d);
    endtask : check_switch

    // quarter-wave sine around mid scale for six phase bits
    function automatic logic [10:0] sine_exp(input logic [5:0] a);
        int k;
        int t;
        k = a[4] ? 15 - a[3:0] : a[3:0];
        t = $rtoi(1023.0 * $sin((k + 0.5) * 3.14159265358979 / 32.0) + 0.5);
        return a[5] ? 11'(1024 - t) : 11'(1024 + t);
    endfunction : sine_exp

    // sample shows the table entry of the phase two clocks earlier
    task automatic check_dac;
        dds_pkg::word_type h0;
        dds_pkg::word_type h1;
        @(posedge mclk) #1 h0 = phase;
        @(posedge mclk) #1 h1 = phase;
        repeat (8) begin
            @(posedge mclk) #1;
            chk("dac", {13'h0, sine_exp(h0[23:18])}, {13'h0, dac_sample});
            h0 = h1;
            h1 = phase;
        end
    endtask : check_dac

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #300000;
        fails++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence; leading nibble 4'hC must be discarded
    initial begin
        fails   = 0;
        n_tests = 0;
        srst    = 1'b1;
        ce      = 1'b1;
        mode    = 1'b0;
        tx_data = 1'b0;
        stdby   = 1'b0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk) #1;
        chk("phase reset", 24'h000000, phase);
        chk("dac reset", 24'h000400, {13'h0, dac_sample});
        $display("test reset done");

        host_u.send_word({4'hC, 2'b00, 22'h123456});
        check_step("step f0", 24'h123456);
        host_u.send_word({4'hC, 2'b01, 22'h3FFFFF});
        check_step("mode0 kept", 24'h123456);
        @(posedge mclk) mode <= 1'b1;
        check_switch("mode1", 24'h123456, 24'h3FFFFF);
        check_dac();
        $display("test frequency select done");

        host_u.send_word({4'hC, 2'b10, 5'h00, 1'b1, 8'h00, 8'hFF});
        @(posedge mclk) tx_data <= 1'b1;
        repeat (4) @(posedge mclk);
        check_step("fsk off", 24'h3FFFFF);
        host_u.send_word({4'hC, 2'b10, 5'h00, 1'b0, 8'h00, 8'hFF});
        check_step("fsk high", 24'h4003FB);
        @(posedge mclk) tx_data <= 1'b0; // held low from here on
        check_switch("fsk low", 24'h4003FB, 24'h3FFFFF);
        $display("test deviation done");

        host_u.send_word({4'hC, 2'b11, 22'h000001});
        check_step("other latch", 24'h3FFFFF);
        @(posedge mclk) mode <= 1'b0;
        check_switch("f0 kept", 24'h3FFFFF, 24'h123456);
        @(posedge mclk) mode <= 1'b1;
        check_switch("f1 again", 24'h123456, 24'h3FFFFF);
        $display("test refused word done");

        @(posedge mclk) stdby <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 p_hold = phase;
        repeat (5) @(posedge mclk);
        #1 chk("standby hold", p_hold, phase);
        @(posedge mclk) stdby <= 1'b0;
        repeat (4) @(posedge mclk);
        check_step("after standby", 24'h3FFFFF);
        @(posedge mclk) ce <= 1'b0;
        @(posedge mclk) #1 p_hold = phase;
        repeat (5) @(posedge mclk);
        #1 chk("enable hold", p_hold, phase);
        @(posedge mclk) ce <= 1'b1;
        check_step("after enable", 24'h3FFFFF);
        $display("test standby done");
        close_out();
    end

endmodule : test_dds_frequency_synth_core

`default_nettype wire
